// >>> rtl/rswseq_top.sv
// Purpose: reset, stop, wait and external interrupt wake sequencing
// Assumes: inputs synchronous to clk_in; ext_clk_tick_in is a one-cycle enable per external clock period
// Notes:   the core is modelled by grant and status strobes; the sequencer only times them
`timescale 1ns/1ps
// Operation
// RL1: while reset is asserted, bus address, data and control outputs float.
// RL2: external reset source holds reset at least 30 ns.
// RL3: first external address at most 120 core cycles after reset release.
// RL4: reset disables and bypasses pll and enters run mode at source clock.
// RL5: edge interrupt request held at least one cycle plus 3 ns.
// RL6: first service effect no sooner than 18 cycles, 14 in fast mode.
// RL7: vector address after wait wake no sooner than 22 cycles, 18 fast.
// RL8: wait exit data access after 18 cycles fast or 22 ext periods normal.
// RL9: interrupt fetch shown on pins only in mode 3.
// RL10: fast recovery on direct external clock or mode bit 6; pll keeps running.
// RL11: fast wake one cycle shorter, clock period unchanged over stop.
// RL12: normal stop bypasses pll then halts master clock; wakes at source rate.
// RL13: normal stop wake spends one extra cycle restarting master clock.
// RL14: reset output lasts 128 ext periods normally, 8 in internal reset mode.
module rswseq_top #(
    parameter int OMR_W = rswseq_pkg::OMR_WIDTH
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             ext_clk_tick_in,
    // configuration
    input  wire logic [OMR_W-1:0] operating_mode_reg_in,
    input  wire logic             direct_ext_clk_in,
    input  wire logic [1:0]       boot_mode_in,
    input  wire logic             internal_reset_mode_in,
    // interrupt lines, active low
    input  wire logic             ext_irq_line_a_in,
    input  wire logic             ext_irq_line_b_in,
    // core power requests
    input  wire logic             wait_req_in,
    input  wire logic             stop_req_in,
    // bus
    output logic                  bus_oe_out,
    output logic                  bus_start_out,
    output logic                  irq_fetch_visible_out,
    // wake timing strobes
    output logic                  svc_effect_ok_out,
    output logic                  vector_ok_out,
    output logic                  data_access_ok_out,
    // clocking control
    output logic                  pll_enable_out,
    output logic                  pll_bypass_out,
    output logic                  master_clk_en_out,
    output logic                  run_mode_out,
    // reset output
    output logic                  reset_out_pin_out
);
    typedef enum logic [2:0] {RSWSEQ_RST, RSWSEQ_BOOT, RSWSEQ_RUN, RSWSEQ_WAIT, RSWSEQ_STOP,
                              RSWSEQ_RESTART, RSWSEQ_WAKE} rswseq_state_e;
    localparam logic [7:0] BOOT_CYC   = 8'(rswseq_pkg::FIRST_ADDR_MAX_CYC - 1);
    localparam logic [7:0] EFF_N      = 8'(rswseq_pkg::IRQ_EFFECT_CYC);
    localparam logic [7:0] EFF_F      = 8'(rswseq_pkg::IRQ_EFFECT_FAST_CYC);
    localparam logic [7:0] VEC_N      = 8'(rswseq_pkg::WAIT_VEC_CYC);
    localparam logic [7:0] VEC_F      = 8'(rswseq_pkg::WAIT_VEC_FAST_CYC);
    localparam logic [7:0] DAT_F      = 8'(rswseq_pkg::WAIT_DATA_FAST_CYC);
    localparam logic [7:0] DAT_NE     = 8'(rswseq_pkg::WAIT_DATA_NORM_EXT);
    localparam logic [7:0] RESET_OUT_PIN_N     = 8'(rswseq_pkg::RESET_OUT_PIN_NORM_EXT);
    localparam logic [7:0] RESET_OUT_PIN_I     = 8'(rswseq_pkg::RESET_OUT_PIN_INT_EXT);

    rswseq_state_e state;
    logic [7:0]    boot_cnt;
    logic [7:0]    core_cnt;
    logic [7:0]    ext_cnt;
    logic [7:0]    reset_out_pin_cnt;
    logic          irq_a_q;
    logic          irq_b_q;
    logic          irq_edge;
    logic          irq_a_edge;
    logic          fast;
    logic          from_wait;
    logic          armed;

    ////////////////////////////////////////////////////////////////////////
    // fast recovery selection
    assign fast = direct_ext_clk_in | operating_mode_reg_in[rswseq_pkg::OMR_FAST_STOP_BIT]; // RL10

    // falling-edge detect; the partner keeps requests a full cycle wide, so one sample is enough
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_a_q <= 1'b1;
            irq_b_q <= 1'b1;
        end else begin
            irq_a_q <= ext_irq_line_a_in; // RL5
            irq_b_q <= ext_irq_line_b_in;
        end
    end
    assign irq_a_edge = irq_a_q & ~ext_irq_line_a_in;
    assign irq_edge   = irq_a_edge | (irq_b_q & ~ext_irq_line_b_in);

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state     <= RSWSEQ_RST;
            boot_cnt  <= 8'h00;
            from_wait <= 1'b0;
        end else begin
            unique case (state)
                RSWSEQ_RST: begin
                    state    <= RSWSEQ_BOOT;
                    boot_cnt <= 8'h00;
                end
                RSWSEQ_BOOT: begin
                    boot_cnt <= boot_cnt + 8'h01;
                    if (boot_cnt == BOOT_CYC - 8'h01)
                        state <= RSWSEQ_RUN; // RL3
                end
                RSWSEQ_RUN: begin
                    if (stop_req_in) begin
                        state <= RSWSEQ_STOP;
                    end else if (wait_req_in) begin
                        state <= RSWSEQ_WAIT;
                    end
                end
                RSWSEQ_WAIT: begin
                    if (irq_a_edge) begin
                        state     <= RSWSEQ_WAKE;
                        from_wait <= 1'b1;
                    end
                end
                RSWSEQ_STOP: begin
                    if (irq_a_edge) begin
                        from_wait <= 1'b0;
                        state     <= fast ? RSWSEQ_WAKE : RSWSEQ_RESTART; // RL11
                    end
                end
                RSWSEQ_RESTART: begin
                    state <= RSWSEQ_WAKE; // RL13
                end
                RSWSEQ_WAKE: begin
                    state <= RSWSEQ_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and clocking outputs
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            bus_oe_out        <= 1'b0; // RL1
            bus_start_out     <= 1'b0;
            pll_enable_out    <= 1'b0; // RL4
            pll_bypass_out    <= 1'b1;
            master_clk_en_out <= 1'b1;
            run_mode_out      <= 1'b1;
        end else begin
            bus_start_out <= (state == RSWSEQ_BOOT) && (boot_cnt == BOOT_CYC - 8'h01); // RL3
            if (bus_start_out)
                bus_oe_out <= 1'b1;
            run_mode_out <= (state == RSWSEQ_RST) || (state == RSWSEQ_RUN) || (state == RSWSEQ_BOOT); // RL4
            if (state == RSWSEQ_RUN && stop_req_in && !fast) begin
                pll_enable_out    <= 1'b0; // RL12
                pll_bypass_out    <= 1'b1;
                master_clk_en_out <= 1'b0;
            end else if (state == RSWSEQ_RESTART) begin
                master_clk_en_out <= 1'b1; // RL13
            end else if (state == RSWSEQ_RUN && stop_req_in) begin
                master_clk_en_out <= 1'b1; // RL10
            end
        end
    end
    assign irq_fetch_visible_out = bus_oe_out && (boot_mode_in == rswseq_pkg::MODE_EXPOSE); // RL9

    ////////////////////////////////////////////////////////////////////////
    // wake latency counters; counts saturate so strobes stay high until next request
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            core_cnt <= 8'h00;
            ext_cnt  <= 8'h00;
            armed    <= 1'b0;
        end else if (irq_edge) begin
            // start from zero: the pin fell half a cycle before this edge, so a start at one lands early
            core_cnt <= 8'h00;
            ext_cnt  <= 8'h00;
            armed    <= 1'b1;
        end else if (armed) begin
            if (core_cnt != 8'hff)
                core_cnt <= core_cnt + 8'h01;
            if (ext_clk_tick_in && ext_cnt != 8'hff)
                ext_cnt <= ext_cnt + 8'h01;
        end
    end
    always_comb begin
        svc_effect_ok_out  = armed && (core_cnt >= (fast ? EFF_F : EFF_N)); // RL6
        vector_ok_out      = armed && from_wait && (core_cnt >= (fast ? VEC_F : VEC_N)); // RL7
        data_access_ok_out = armed && from_wait &&
                             (fast ? (core_cnt >= DAT_F) : (ext_cnt >= DAT_NE)); // RL8
    end

    ////////////////////////////////////////////////////////////////////////
    // reset output pulse, counted in external clock periods
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reset_out_pin_cnt          <= 8'h00;
            reset_out_pin_out <= 1'b1;
        end else if (reset_out_pin_out) begin
            if (ext_clk_tick_in)
                reset_out_pin_cnt <= reset_out_pin_cnt + 8'h01;
            if (ext_clk_tick_in && reset_out_pin_cnt + 8'h01 >= (internal_reset_mode_in ? RESET_OUT_PIN_I : RESET_OUT_PIN_N))
                reset_out_pin_out <= 1'b0; // RL14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_boot_start;
        $rose(resetn_in);
    endsequence
    property p_bus_float;
        @(posedge clk_in) !resetn_in |=> !bus_oe_out;
    endproperty
    a_bus_float: assert property (p_bus_float) else $error("bus driven during reset"); // RL1
    property p_first_addr;
        @(posedge clk_in) disable iff (!resetn_in) s_boot_start |-> ##[1:120] bus_start_out;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first address late"); // RL3
    property p_pll_reset;
        @(posedge clk_in) !resetn_in |=> pll_bypass_out && !pll_enable_out && run_mode_out;
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("pll not bypassed at reset"); // RL4
    sequence s_svc_low8;
        !svc_effect_ok_out [*8];
    endsequence
    // fourteen quiet cycles, the fast-mode floor, is all that is checked in either recovery mode
    property p_eff_min;
        @(posedge clk_in) disable iff (!resetn_in) irq_edge |=> s_svc_low8 ##1 !svc_effect_ok_out [*6];
    endproperty
    a_eff_min: assert property (p_eff_min) else $error("service effect too early"); // RL6
    sequence s_vec_low8;
        !vector_ok_out [*8];
    endsequence
    property p_vec_min;
        @(posedge clk_in) disable iff (!resetn_in)
            state == RSWSEQ_WAIT && irq_a_edge |=> s_vec_low8 ##1 s_vec_low8 ##1 !vector_ok_out [*2];
    endproperty
    a_vec_min: assert property (p_vec_min) else $error("vector too early"); // RL7
    property p_data_norm;
        @(posedge clk_in) disable iff (!resetn_in) data_access_ok_out && !fast |-> ext_cnt >= DAT_NE;
    endproperty
    a_data_norm: assert property (p_data_norm) else $error("data access too early"); // RL8
    property p_expose;
        @(posedge clk_in) irq_fetch_visible_out |-> boot_mode_in == rswseq_pkg::MODE_EXPOSE;
    endproperty
    a_expose: assert property (p_expose) else $error("fetch shown outside mode 3"); // RL9
    property p_fast_clk;
        @(posedge clk_in) disable iff (!resetn_in)
            state == RSWSEQ_RUN && stop_req_in && fast |=> master_clk_en_out;
    endproperty
    a_fast_clk: assert property (p_fast_clk) else $error("clock stopped in fast stop"); // RL10
    property p_restart;
        @(posedge clk_in) disable iff (!resetn_in)
            state == RSWSEQ_STOP && irq_a_edge && !fast |=> state == RSWSEQ_RESTART ##1 state == RSWSEQ_WAKE;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart cycle"); // RL13
    property p_norm_stop;
        @(posedge clk_in) disable iff (!resetn_in)
            state == RSWSEQ_RUN && stop_req_in && !fast |=> !master_clk_en_out && pll_bypass_out;
    endproperty
    a_norm_stop: assert property (p_norm_stop) else $error("normal stop kept clock"); // RL12
    property p_reset_out_pin;
        @(posedge clk_in) disable iff (!resetn_in) $fell(reset_out_pin_out) |->
            reset_out_pin_cnt >= (internal_reset_mode_in ? RESET_OUT_PIN_I : RESET_OUT_PIN_N);
    endproperty
    a_reset_out_pin: assert property (p_reset_out_pin) else $error("reset output too short"); // RL14
endmodule

// >>> pkg/rswseq_pkg.sv
// Purpose: constants for the reset / stop / wait wake sequencer
// Assumes: core clock clk_in at 250 MHz
// Notes:   all timing counts derive from the figures below
package rswseq_pkg;
    localparam int CLK_PERIOD_PS       = 4000;
    // reset input minimum width, ns
    localparam int RESET_MIN_NS        = 30;
    localparam int RESET_MIN_CYC       = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // core cycles after reset release to first bus address (longest)
    localparam int FIRST_ADDR_MAX_CYC  = 120;
    // irq to first service effect, normal and fast
    localparam int IRQ_EFFECT_CYC      = 18;
    localparam int IRQ_EFFECT_FAST_CYC = 14;
    // irq a low to vector out from wait
    localparam int WAIT_VEC_CYC        = 22;
    localparam int WAIT_VEC_FAST_CYC   = 18;
    // irq a ending wait to data access: fast in core cycles, normal in ext periods
    localparam int WAIT_DATA_FAST_CYC  = 18;
    localparam int WAIT_DATA_NORM_EXT  = 22;
    // reset output pulse in external clock periods
    localparam int RESET_OUT_PIN_NORM_EXT       = 128;
    localparam int RESET_OUT_PIN_INT_EXT        = 8;
    // operating mode register bits
    localparam int OMR_FAST_STOP_BIT   = 6;
    localparam int OMR_WIDTH           = 16;
    localparam logic [1:0] MODE_EXPOSE = 2'h3;
    localparam int CNT_W               = 8;
endpackage

// >>> tb/rswseq_ext_model.sv
// Purpose: far-side model: reset source, interrupt lines and external clock ticks
// Assumes: everything changes on the falling edge of clk_in
// Notes:   external clock is one tick every four core cycles
`timescale 1ns/1ps
module rswseq_ext_model (
    // clock
    input  wire logic clk_in,
    // far-side drives
    output logic      resetn_out,
    output logic      ext_clk_tick_out,
    output logic      ext_irq_line_a_out,
    output logic      ext_irq_line_b_out
);
    logic [1:0] tick_cnt;

    initial begin
        resetn_out = 1'b0;
        tick_cnt = 2'h0;
        ext_clk_tick_out = 1'b0;
        ext_irq_line_a_out = 1'b1;
        ext_irq_line_b_out = 1'b1;
    end

    always @(negedge clk_in) begin
        tick_cnt <= tick_cnt + 2'h1;
        ext_clk_tick_out <= (tick_cnt == 2'h3);
    end

    ////////////////////////////////////////////////////////////////////////////
    // never shorter than 8 cycles: anything less is under 30 ns at 4 ns a cycle
    task automatic hold_reset(input int cycles);
        resetn_out = 1'b0;
        repeat ((cycles < 8) ? 8 : cycles) @(negedge clk_in);
        resetn_out = 1'b1;
    endtask

    task automatic irq_assert(input logic line_b);
        if (line_b) ext_irq_line_b_out = 1'b0;
        else ext_irq_line_a_out = 1'b0;
    endtask

    // idle gap so the next assertion is a fresh falling edge
    task automatic irq_release(input logic line_b);
        if (line_b) ext_irq_line_b_out = 1'b1;
        else ext_irq_line_a_out = 1'b1;
        repeat (2) @(negedge clk_in);
    endtask
endmodule

// >>> tb/test_reset_stop_wake_sequencer.sv
// Purpose: self-checking bench for the reset / stop / wait wake sequencer
// Assumes: far-side model drives reset, interrupt lines and external ticks
// Notes:   strobe times are counted in cycles and ticks after the irq edge cycle
`timescale 1ns/1ps
module test_reset_stop_wake_sequencer;
    logic        clk_in;
    logic        resetn, tick, irq_a, irq_b;
    logic [15:0] operating_mode_reg;
    logic [1:0]  boot_mode;
    logic        direct_clk, int_rst, wait_req, stop_req;
    logic        bus_oe, bus_start, fetch_vis, svc_ok, vec_ok, data_ok;
    logic        pll_en, pll_byp, mclk_en, run_mode, rst_out;
    int          err_count, tests_run, wn, wf;
    int          cyc[4];
    int          tk[4];

    rswseq_ext_model ext (.clk_in(clk_in), .resetn_out(resetn), .ext_clk_tick_out(tick),
        .ext_irq_line_a_out(irq_a), .ext_irq_line_b_out(irq_b));
    rswseq_top DUT (.clk_in(clk_in), .resetn_in(resetn), .ext_clk_tick_in(tick),
        .operating_mode_reg_in(operating_mode_reg), .direct_ext_clk_in(direct_clk), .boot_mode_in(boot_mode),
        .internal_reset_mode_in(int_rst), .ext_irq_line_a_in(irq_a), .ext_irq_line_b_in(irq_b),
        .wait_req_in(wait_req), .stop_req_in(stop_req), .bus_oe_out(bus_oe), .bus_start_out(bus_start),
        .irq_fetch_visible_out(fetch_vis), .svc_effect_ok_out(svc_ok), .vector_ok_out(vec_ok),
        .data_access_ok_out(data_ok), .pll_enable_out(pll_en), .pll_bypass_out(pll_byp),
        .master_clk_en_out(mclk_en), .run_mode_out(run_mode), .reset_out_pin_out(rst_out));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_num(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // first rise of svc, vector, data and run, in cycles and ticks after the edge cycle
    task automatic watch(input int span);
        logic [3:0] s;
        int n;
        int t;
        n = 0;
        t = 0;
        for (int i = 0; i < 4; i++) begin
            cyc[i] = -1;
            tk[i] = -1;
        end
        @(posedge clk_in);
        repeat (span) begin
            @(posedge clk_in);
            n++;
            if (tick === 1'b1) t++;
            @(negedge clk_in);
            s = {run_mode, data_ok, vec_ok, svc_ok};
            for (int i = 0; i < 4; i++) begin
                if (s[i] === 1'b1 && cyc[i] < 0) begin
                    cyc[i] = n;
                    tk[i] = t;
                end
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset(input logic internal);
        int n;
        int t;
        int bs;
        int_rst = internal;
        ext.hold_reset(8);
        check_bit(bus_oe, 1'b0);
        check_bit(pll_en, 1'b0);
        check_bit(pll_byp, 1'b1);
        check_bit(run_mode, 1'b1);
        check_bit(rst_out, 1'b1);
        n = 0;
        t = 0;
        bs = -1;
        while (rst_out === 1'b1 && n < 1000) begin
            @(posedge clk_in);
            n++;
            if (tick === 1'b1) t++;
            @(negedge clk_in);
            if (bus_start === 1'b1 && bs < 0) bs = n;
        end
        if (!internal) begin
            check_bit(bs > 0 && bs <= 120, 1'b1);
            check_bit(bus_oe, 1'b1);
        end
        check_bit(t >= (internal ? 8 : 128) && t <= (internal ? 10 : 130), 1'b1);
        $display("reset test done, internal mode %0d", internal);
    endtask

    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            boot_mode = m[1:0];
            @(negedge clk_in);
            check_bit(fetch_vis, m == 3);
        end
        boot_mode = 2'h0;
        $display("mode test done");
    endtask

    task automatic t_irq(input logic fast_bit, input logic direct);
        // other mode bits set so that only bit 6 may select fast recovery
        operating_mode_reg = {9'h1a5, fast_bit, 6'h2a};
        direct_clk = direct;
        ext.irq_assert(1'b1);
        watch(40);
        ext.irq_release(1'b1);
        check_num(cyc[0], (fast_bit || direct) ? 14 : 18);
        $display("irq test done, fast bit %0d direct %0d", fast_bit, direct);
    endtask

    task automatic t_wait(input logic fast);
        operating_mode_reg = {9'h0f0, fast, 6'h3c};
        direct_clk = 1'b0;
        wait_req = 1'b1;
        repeat (3) @(negedge clk_in);
        wait_req = 1'b0;
        ext.irq_assert(1'b0);
        watch(120);
        ext.irq_release(1'b0);
        check_num(cyc[1], fast ? 18 : 22);
        if (fast) check_num(cyc[2], 18);
        else check_num(tk[2], 22);
        $display("wait test done, fast %0d", fast);
    endtask

    task automatic t_stop(input logic fast, output int wake);
        logic pe;
        // fast stop here comes from the direct external clock; bit 6 is covered by irq and wait tests
        operating_mode_reg = {9'h0aa, 1'b0, 6'h15};
        direct_clk = fast;
        pe = pll_en;
        stop_req = 1'b1;
        repeat (3) @(negedge clk_in);
        stop_req = 1'b0;
        check_bit(mclk_en, fast);
        if (fast) check_bit(pll_en, pe);
        else check_bit(pll_byp, 1'b1);
        ext.irq_assert(1'b0);
        watch(40);
        ext.irq_release(1'b0);
        wake = cyc[3];
        check_bit(mclk_en, 1'b1);
        $display("stop test done, fast %0d", fast);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end

    initial begin
        err_count = 0;
        tests_run = 0;
        operating_mode_reg = 16'h0000;
        boot_mode = 2'h0;
        direct_clk = 1'b0;
        int_rst = 1'b0;
        wait_req = 1'b0;
        stop_req = 1'b0;
        @(negedge clk_in);
        t_reset(1'b0);
        t_mode();
        t_irq(1'b0, 1'b0);
        t_irq(1'b1, 1'b0);
        t_irq(1'b0, 1'b1);
        t_wait(1'b0);
        t_wait(1'b1);
        t_stop(1'b0, wn);
        t_stop(1'b1, wf);
        check_num(wn - wf, 1);
        t_reset(1'b1);
        wrap_up();
    end
endmodule
